/* idm_pkg.sv */
// constants and types for the internal data memory map decoder
// Summary of operation
// R1: byte operand addresses span 0 to 255
// R2: four eight-register banks at RAM 0..31
// R3: status word two-bit field selects one bank
// R4: bit addresses 00..7F map onto bytes 20H..2FH
// R5: lower 128 bytes direct or indirect
// R6: upper indirect goes RAM, upper direct goes SFR
// R7: special registers 128..255, direct access only
// R8: all registers except PC and the four banks live in SFR window
// R9: eight-bit stack pointer anywhere in RAM
// R10: calls save PC; push/pop any direct byte
// R11: extended RAM reached only by data pointer moves
// R12: teletext capture buffer at F400..F7FF
// R13: display chapters at C000..DFFF or C000..C3FF
// R14: unused buffer and chapter space is general RAM
// R15: SFR bits only at bytes divisible by eight
// R16: direct address top bit picks RAM or SFR
// R17: indirect pointer from first or second register
// R18: register address is bank times eight plus index
// R19: RAM bit byte is 20H plus upper bits
package idm_pkg;
	localparam logic [7:0] IDM_SFR_BASE = 8'h80; // first special register address
	localparam logic [7:0] IDM_BIT_RAM_BASE = 8'h20; // first bit-addressable byte
	localparam logic [7:0] IDM_PSW_ADDR = 8'hD0; // program_status_word offset
	localparam logic [7:0] IDM_PSW_RESET = 8'h00; // program_status_word reset value
	localparam logic [7:0] IDM_SP_ADDR = 8'h81; // stack pointer offset
	localparam logic [7:0] IDM_SP_RESET = 8'h07; // stack pointer reset value
	localparam logic [7:0] IDM_DPL_ADDR = 8'h82; // data pointer low offset
	localparam logic [7:0] IDM_DPH_ADDR = 8'h83; // data pointer high offset
	localparam logic [7:0] IDM_DP_RESET = 8'h00; // data pointer byte reset value
	localparam int IDM_BANK_LSB = 3; // bank field low bit in status word
	localparam int IDM_BANK_MSB = 4; // bank field high bit in status word
	localparam logic [15:0] IDM_TTX_LO = 16'hF400; // capture buffer start
	localparam logic [15:0] IDM_TTX_HI = 16'hF7FF; // capture buffer end
	localparam logic [15:0] IDM_CHAP_LO = 16'hC000; // display chapters start
	localparam logic [15:0] IDM_CHAP_HI_FULL = 16'hDFFF; // chapters end, large variant
	localparam logic [15:0] IDM_CHAP_HI_SMALL = 16'hC3FF; // chapters end, small variant
	localparam logic [15:0] IDM_CPU_LO = 16'hF800; // cpu extended ram start
	localparam logic [15:0] IDM_CPU_HI = 16'hFBFF; // cpu extended ram end
	// access modes presented by the core
	typedef enum logic [1:0] {
		IDM_DIRECT = 2'b00,
		IDM_INDIRECT = 2'b01,
		IDM_BIT = 2'b10,
		IDM_EXTERNAL = 2'b11
	} idm_mode_type;
endpackage

/* idm_ram.sv */
// single-port byte memory with registered read data
`timescale 1ns/1ps
module idm_ram #(
	parameter int AW = 8,
	parameter int DW = 8
) (
	// clocking
	input wire logic clk,
	input wire logic ce,
	// access
	input wire logic we,
	input wire logic [AW-1:0] addr,
	input wire logic [DW-1:0] wdata,
	output logic [DW-1:0] rdata
);
	logic [DW-1:0] mem [0:(1<<AW)-1]; // storage, no reset on purpose
	// read before write, read data registered
	always_ff @(posedge clk) begin
		if (ce) begin
			if (we) begin
				mem[addr] <= wdata;
			end
			rdata <= mem[addr];
		end
	end
endmodule // idm_ram

/* idm_map.sv */
// internal data memory map: RAM, banks, bit area, SFR window, extended RAM
`timescale 1ns/1ps
module idm_map import idm_pkg::*; #(
	parameter int XAW = 14, // extended ram index width (16 KB array holds 10 KB)
	parameter bit SMALL_VARIANT = 1'b0 // chapters cut to one kilobyte
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// core request
	input wire logic req,
	input wire idm_mode_type mode,
	input wire logic wr,
	input wire logic [7:0] addr,
	input wire logic use_reg,
	input wire logic [2:0] reg_idx,
	input wire logic ptr_sel,
	input wire logic [7:0] wdata,
	input wire logic bit_wdata,
	// answer
	output logic [7:0] rdata_r,
	output logic bit_rdata_r,
	output logic ack_r,
	output logic err_r,
	// state visible to the core
	output logic [7:0] program_status_word,
	output logic [7:0] stack_pointer,
	output logic [15:0] data_pointer_pair,
	// other special registers live outside
	output logic sfr_wr,
	output logic [7:0] sfr_addr,
	output logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata
);
	logic [7:0] psw_r; // status word, holds bank select
	logic [7:0] sp_r; // stack pointer
	logic [7:0] dpl_r; // data pointer low
	logic [7:0] dph_r; // data pointer high
	logic [1:0] bank; // selected bank
	logic [7:0] ram_a; // internal ram address
	logic ram_we; // internal ram write
	logic [7:0] ram_wd; // internal ram write data
	logic [7:0] ram_rd; // internal ram read data
	logic is_sfr; // direct or bit access to window
	logic [7:0] sfr_byte; // byte address for ram or sfr bit access
	logic [2:0] bitpos; // bit within byte
	logic [2:0] bitpos_r; // bit position held for answer
	logic [1:0] phase_r; // 0 idle, 1 pointer fetched
	logic [7:0] sfr_local; // read mux of local sfrs
	logic [15:0] xa; // extended address
	logic x_ok; // extended address mapped
	logic x_we; // extended write
	logic [7:0] x_rd; // extended read data
	logic pending_x_r; // answer comes from extended ram
	logic pending_sfr_r; // answer comes from sfr bus
	logic pending_bit_r; // answer is a bit
	logic [7:0] sfr_hold_r; // sampled sfr read
	logic rmw_r; // ram bit write in progress
	logic [7:0] rmw_a_r; // address of the byte being modified
	logic rmw_bit_r; // bit value to write

	assign bank = psw_r[IDM_BANK_MSB:IDM_BANK_LSB]; // [R3]
	assign program_status_word = psw_r;
	assign stack_pointer = sp_r; // [R9]
	assign data_pointer_pair = {dph_r, dpl_r};
	assign xa = data_pointer_pair; // extended ram is only reached via the pointer [R11]

	// bit address decode: ram area or sfr byte, low three bits select the bit
	always_comb begin
		bitpos = addr[2:0];
		if (!addr[7]) begin
			sfr_byte = IDM_BIT_RAM_BASE + {4'h0, addr[6:3]}; // [R4] [R19]
		end else begin
			sfr_byte = {addr[7:3], 3'h0}; // byte divisible by eight [R15]
		end
	end

	// window decode: top bit of a direct address picks the window [R16] [R7] [R6]
	assign is_sfr = addr[7] && (mode == IDM_DIRECT || (mode == IDM_BIT));

	// ram address: bank register, pointer register or plain address
	always_comb begin
		ram_a = addr;
		if (rmw_r) begin
			ram_a = rmw_a_r;
		end else if (mode == IDM_BIT) begin
			ram_a = sfr_byte;
		end else if (use_reg) begin
			ram_a = {3'h0, bank, reg_idx}; // [R2] [R18]
		end else if (mode == IDM_INDIRECT && phase_r == 2'd1) begin
			ram_a = ram_rd; // pointer fetched from first/second register [R17]
		end else if (mode == IDM_INDIRECT) begin
			ram_a = {3'h0, bank, 2'b00, ptr_sel}; // [R17]
		end
	end

	// write into the lower or upper ram; direct writes above 127 go to sfrs [R5] [R6]
	always_comb begin
		ram_we = 1'b0;
		ram_wd = wdata;
		if (ce && rmw_r) begin
			ram_we = 1'b1;
			ram_wd = ram_rd;
			ram_wd[bitpos_r] = rmw_bit_r;
		end else if (ce && req && wr && phase_r == 2'd0 && !is_sfr) begin
			ram_we = (mode == IDM_DIRECT) || use_reg;
		end else if (ce && req && wr && mode == IDM_INDIRECT && phase_r == 2'd1) begin
			ram_we = 1'b1;
		end
	end

	// 256 bytes cover byte operand addresses 0..255 [R1]
	idm_ram #(.AW(8), .DW(8)) u_iram (
		.clk(clk),
		.ce(ce),
		.we(ram_we),
		.addr(ram_a),
		.wdata(ram_wd),
		.rdata(ram_rd)
	);

	// extended ram regions; unused buffer space is plain ram [R12] [R13] [R14]
	always_comb begin
		x_ok = (xa >= IDM_TTX_LO && xa <= IDM_TTX_HI);
		if (SMALL_VARIANT) begin
			// small parts carry short chapters and no cpu extended ram
			x_ok = x_ok || (xa >= IDM_CHAP_LO && xa <= IDM_CHAP_HI_SMALL);
		end else begin
			x_ok = x_ok || (xa >= IDM_CHAP_LO && xa <= IDM_CHAP_HI_FULL);
			x_ok = x_ok || (xa >= IDM_CPU_LO && xa <= IDM_CPU_HI);
		end
	end
	assign x_we = ce && req && wr && mode == IDM_EXTERNAL && x_ok && phase_r == 2'd0; // [R11]

	idm_ram #(.AW(XAW), .DW(8)) u_extended_onchip_ram (
		.clk(clk),
		.ce(ce),
		.we(x_we),
		.addr(xa[XAW-1:0]),
		.wdata(wdata),
		.rdata(x_rd)
	);

	// outside sfr strobe, used for direct writes to every window register we do not hold [R8]
	// byte accesses keep their own address; only bit accesses use the aligned byte [R15]
	assign sfr_addr = (mode == IDM_BIT) ? sfr_byte : addr;
	assign sfr_wdata = wdata;
	assign sfr_wr = ce && req && wr && phase_r == 2'd0 && mode == IDM_DIRECT && addr[7]
		&& addr != IDM_PSW_ADDR && addr != IDM_SP_ADDR && addr != IDM_DPL_ADDR
		&& addr != IDM_DPH_ADDR;

	// local sfr read mux
	always_comb begin
		case (sfr_addr)
			IDM_PSW_ADDR: sfr_local = psw_r;
			IDM_SP_ADDR: sfr_local = sp_r;
			IDM_DPL_ADDR: sfr_local = dpl_r;
			IDM_DPH_ADDR: sfr_local = dph_r;
			default: sfr_local = sfr_rdata;
		endcase
	end

	// local special registers, direct writes and sfr bit writes [R7] [R10]
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			psw_r <= IDM_PSW_RESET;
			sp_r <= IDM_SP_RESET;
			dpl_r <= IDM_DP_RESET;
			dph_r <= IDM_DP_RESET;
		end else if (ce && req && wr && phase_r == 2'd0 && addr[7]) begin
			if (mode == IDM_DIRECT) begin
				case (addr)
					IDM_PSW_ADDR: psw_r <= wdata;
					IDM_SP_ADDR: sp_r <= wdata;
					IDM_DPL_ADDR: dpl_r <= wdata;
					IDM_DPH_ADDR: dph_r <= wdata;
					default: ;
				endcase
			end else if (mode == IDM_BIT && sfr_byte == IDM_PSW_ADDR) begin
				psw_r[bitpos] <= bit_wdata; // [R15]
			end
		end
	end

	// sequencing: indirect needs a pointer fetch, ram bit write needs read-modify
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			phase_r <= 2'd0;
			rmw_r <= 1'b0;
			rmw_a_r <= 8'h00;
			rmw_bit_r <= 1'b0;
			bitpos_r <= 3'h0;
			ack_r <= 1'b0;
			err_r <= 1'b0;
			pending_x_r <= 1'b0;
			pending_sfr_r <= 1'b0;
			pending_bit_r <= 1'b0;
			sfr_hold_r <= 8'h00;
		end else if (ce) begin
			ack_r <= 1'b0;
			err_r <= 1'b0;
			rmw_r <= 1'b0;
			if (rmw_r) begin
				ack_r <= 1'b1;
			end else if (req && phase_r == 2'd0 && mode == IDM_INDIRECT && !use_reg) begin
				phase_r <= 2'd1; // pointer fetched, next cycle uses it [R17]
			end else if (req && (phase_r == 2'd1 || mode != IDM_INDIRECT || use_reg)) begin
				phase_r <= 2'd0;
				bitpos_r <= bitpos;
				pending_x_r <= mode == IDM_EXTERNAL;
				pending_sfr_r <= is_sfr && !use_reg;
				pending_bit_r <= mode == IDM_BIT;
				sfr_hold_r <= sfr_local;
				err_r <= mode == IDM_EXTERNAL && !x_ok; // unmapped extended address [R11]
				if (mode == IDM_BIT && wr && !addr[7]) begin
					rmw_r <= 1'b1; // [R4]
					rmw_a_r <= sfr_byte;
					rmw_bit_r <= bit_wdata;
				end else begin
					ack_r <= 1'b1;
				end
			end else begin
				phase_r <= 2'd0; // a dropped request abandons a half-done pointer fetch
			end
		end
	end

	// answer data from the chosen source
	always_comb begin
		rdata_r = pending_x_r ? x_rd : (pending_sfr_r ? sfr_hold_r : ram_rd);
		bit_rdata_r = rdata_r[bitpos_r];
	end

	AST_BANK_ADDR: assert property (@(posedge clk) disable iff (rst) // [R18]
		(ce && use_reg && !rmw_r) |-> ram_a == {3'h0, bank, reg_idx})
		else $error("bank register address wrong");
	AST_DIRECT_HIGH_NO_RAM: assert property (@(posedge clk) disable iff (rst) // [R7]
		(req && mode == IDM_DIRECT && addr[7] && !use_reg && !rmw_r) |-> !ram_we)
		else $error("direct high write reached ram");
	AST_BIT_BYTE: assert property (@(posedge clk) disable iff (rst) // [R4]
		(mode == IDM_BIT && !addr[7]) |-> sfr_byte == IDM_BIT_RAM_BASE + addr[6:3])
		else $error("ram bit byte wrong");
	AST_SFR_BIT_ALIGN: assert property (@(posedge clk) disable iff (rst) // [R15]
		(mode == IDM_BIT && addr[7]) |-> sfr_byte[2:0] == 3'h0)
		else $error("sfr bit byte not aligned");
	AST_INDIRECT_PTR: assert property (@(posedge clk) disable iff (rst) // [R17]
		(ce && req && mode == IDM_INDIRECT && !use_reg && phase_r == 2'd0 && !rmw_r)
		|-> ram_a == {3'h0, bank, 2'b00, ptr_sel})
		else $error("indirect pointer register wrong");
	AST_PSW_WRITE: assert property (@(posedge clk) disable iff (rst) // [R3]
		(ce && req && wr && mode == IDM_DIRECT && addr == IDM_PSW_ADDR && phase_r == 2'd0)
		|=> psw_r == $past(wdata))
		else $error("status word not written");
	AST_EXTENDED_ONCHIP_RAM_MAP: assert property (@(posedge clk) disable iff (rst) // [R12]
		x_we |-> ((xa >= IDM_TTX_LO && xa <= IDM_TTX_HI)
		|| (!SMALL_VARIANT && xa >= IDM_CPU_LO && xa <= IDM_CPU_HI)
		|| (xa >= IDM_CHAP_LO && xa <= (SMALL_VARIANT ? IDM_CHAP_HI_SMALL : IDM_CHAP_HI_FULL))))
		else $error("extended write outside map");
	AST_SP_WRITE: assert property (@(posedge clk) disable iff (rst) // [R9]
		(ce && req && wr && mode == IDM_DIRECT && addr == IDM_SP_ADDR && phase_r == 2'd0)
		|=> sp_r == $past(wdata))
		else $error("stack pointer not written");
	AST_CE_FREEZE: assert property (@(posedge clk) disable iff (rst) // [R3]
		!ce |=> (psw_r == $past(psw_r)) && (sp_r == $past(sp_r)) && (ack_r == $past(ack_r)))
		else $error("state moved while clock enable low");
	COV_INDIRECT: cover property (@(posedge clk) req && mode == IDM_INDIRECT && phase_r == 2'd1);
	COV_BIT_RMW: cover property (@(posedge clk) rmw_r);
	COV_EXTENDED_ONCHIP_RAM: cover property (@(posedge clk) x_we);
	COV_CE_HOLD: cover property (@(posedge clk) !ce && req);
endmodule // idm_map

/* idm_sfr_model.sv */
// model of the special registers that sit outside the map decoder
`timescale 1ns/1ps
module idm_sfr_model (
	// clock
	input wire logic clk,
	// write and read port from the decoder
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata
);
	logic [7:0] regs [128]; // one byte per window slot
	// slots start at the inverse of their address so a stray read shows
	initial begin
		for (int i = 0; i < 128; i++) begin
			regs[i] = ~(8'h80 | 8'(i));
		end
	end
	// writes land on the rising edge
	always @(posedge clk) begin
		if (sfr_wr) begin
			regs[sfr_addr[6:0]] <= sfr_wdata;
		end
	end
	// read is combinational, as the decoder expects
	assign sfr_rdata = regs[sfr_addr[6:0]];
endmodule // idm_sfr_model

/* idm_map_tb_top.sv */
// self-checking bench for the internal data memory map decoder
`timescale 1ns/1ps
module idm_map_tb_top import idm_pkg::*;;
	logic clk, rst, ce, req, wr, use_reg, ptr_sel, bit_wdata, bit_rdata_r, ack_r, err_r, sfr_wr;
	idm_mode_type mode; // access mode to the decoder
	logic [7:0] addr, wdata, rdata_r, program_status_word, stack_pointer;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
	logic [2:0] reg_idx; // working register index
	logic [15:0] data_pointer_pair;
	logic [7:0] rd; // last read byte
	logic rb, re; // last bit and error seen
	int fail_count, samples_checked;
	// extended addresses: first five mapped, last two unmapped
	localparam logic [15:0] XA [7] = '{16'hF400, 16'hF7FF, 16'hC000, 16'hDFFF,
		16'hF800, 16'hE000, 16'h0000};
	idm_map dut (.clk, .rst, .ce, .req, .mode, .wr, .addr, .use_reg, .reg_idx, .ptr_sel,
		.wdata, .bit_wdata, .rdata_r, .bit_rdata_r, .ack_r, .err_r, .program_status_word,
		.stack_pointer, .data_pointer_pair, .sfr_wr, .sfr_addr, .sfr_wdata, .sfr_rdata);
	idm_sfr_model sfrs (.clk, .sfr_wr, .sfr_addr, .sfr_wdata, .sfr_rdata);
	// free-running core clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// verdict in one place
	task summarize;
		$display("comparisons %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one access; latency is fixed per kind, so req drops on the ack edge
	task acc(input idm_mode_type m, input logic w, input logic [7:0] a, input logic u,
		input logic [2:0] i, input logic p, input logic [7:0] d, input logic b, input int lat);
		@(posedge clk);
		req <= 1'b1;
		mode <= m;
		wr <= w;
		addr <= a;
		use_reg <= u;
		reg_idx <= i;
		ptr_sel <= p;
		wdata <= d;
		bit_wdata <= b;
		repeat (lat) @(posedge clk);
		req <= 1'b0;
		#1;
		rd = rdata_r;
		rb = bit_rdata_r;
		re = err_r;
		check(16'(ack_r), 16'h1);
	endtask
	task dw(input logic [7:0] a, input logic [7:0] d);
		acc(IDM_DIRECT, 1'b1, a, 1'b0, 3'h0, 1'b0, d, 1'b0, 1);
	endtask
	task dr(input logic [7:0] a);
		acc(IDM_DIRECT, 1'b0, a, 1'b0, 3'h0, 1'b0, 8'h00, 1'b0, 1);
	endtask
	task rw(input logic [2:0] i, input logic [7:0] d);
		acc(IDM_DIRECT, 1'b1, 8'h00, 1'b1, i, 1'b0, d, 1'b0, 1);
	endtask
	task ind(input logic w, input logic p, input logic [7:0] d);
		acc(IDM_INDIRECT, w, 8'h00, 1'b0, 3'h0, p, d, 1'b0, 2);
	endtask
	task t_reset;
		check(16'(program_status_word), 16'h00);
		check(16'(stack_pointer), 16'h07);
		check(data_pointer_pair, 16'h0000);
		$display("test reset done");
	endtask
	// same register index in two banks must not collide
	task t_banks;
		dw(IDM_PSW_ADDR, 8'h00);
		rw(3'h3, 8'h11);
		dw(IDM_PSW_ADDR, 8'h10);
		rw(3'h3, 8'h5A);
		check(16'(program_status_word), 16'h10);
		dr(8'h03);
		check(16'(rd), 16'h11);
		dr(8'h13);
		check(16'(rd), 16'h5A);
		dw(IDM_PSW_ADDR, 8'h18);
		dw(8'h1F, 8'hE7);
		acc(IDM_DIRECT, 1'b0, 8'h00, 1'b1, 3'h7, 1'b0, 8'h00, 1'b0, 1);
		check(16'(rd), 16'hE7);
		$display("test banks done");
	endtask
	// upper half: indirect reaches ram, direct reaches special registers
	task t_indirect;
		rw(3'h0, 8'h90);
		rw(3'h1, 8'h35);
		dw(8'h35, 8'h77);
		ind(1'b0, 1'b1, 8'h00);
		check(16'(rd), 16'h77);
		ind(1'b1, 1'b0, 8'hC3);
		ind(1'b0, 1'b0, 8'h00);
		check(16'(rd), 16'hC3);
		dr(8'h90);
		check(16'(rd), 16'h6F);
		dw(8'hA8, 8'h3C);
		dr(8'hA8);
		check(16'(rd), 16'h3C);
		dw(IDM_SP_ADDR, 8'h40);
		check(16'(stack_pointer), 16'h40);
		dr(IDM_SP_ADDR);
		check(16'(rd), 16'h40);
		dw(8'hA9, 8'hC5);
		dr(8'hA9);
		check(16'(rd), 16'hC5);
		dr(8'hA8);
		check(16'(rd), 16'h3C);
		$display("test indirect done");
	endtask
	// clock enable low: a held write must leave the status word alone
	task t_ce;
		@(posedge clk);
		ce <= 1'b0;
		req <= 1'b1;
		mode <= IDM_DIRECT;
		wr <= 1'b1;
		addr <= IDM_PSW_ADDR;
		use_reg <= 1'b0;
		wdata <= 8'hE5;
		repeat (3) @(posedge clk);
		req <= 1'b0;
		#1;
		check(16'(ack_r), 16'h0);
		check(16'(program_status_word), 16'h08);
		@(posedge clk);
		ce <= 1'b1;
		$display("test clock enable done");
	endtask
	task t_bits;
		dw(8'h21, 8'h00);
		dw(8'h2F, 8'h00);
		acc(IDM_BIT, 1'b1, 8'h0B, 1'b0, 3'h0, 1'b0, 8'h00, 1'b1, 2);
		acc(IDM_BIT, 1'b1, 8'h7F, 1'b0, 3'h0, 1'b0, 8'h00, 1'b1, 2);
		dr(8'h21);
		check(16'(rd), 16'h08);
		dr(8'h2F);
		check(16'(rd), 16'h80);
		acc(IDM_BIT, 1'b0, 8'h0B, 1'b0, 3'h0, 1'b0, 8'h00, 1'b0, 1);
		check(16'(rb), 16'h1);
		acc(IDM_BIT, 1'b0, 8'hD3, 1'b0, 3'h0, 1'b0, 8'h00, 1'b0, 1);
		check(16'(rb), 16'h1);
		acc(IDM_BIT, 1'b1, 8'hD4, 1'b0, 3'h0, 1'b0, 8'h00, 1'b0, 1);
		check(16'(program_status_word), 16'h08);
		$display("test bits done");
	endtask
	// all regions written before any is read back, so aliasing shows
	task t_ext;
		for (int k = 0; k < 7; k++) begin
			dw(IDM_DPH_ADDR, XA[k][15:8]);
			dw(IDM_DPL_ADDR, XA[k][7:0]);
			check(data_pointer_pair, XA[k]);
			acc(IDM_EXTERNAL, 1'b1, 8'h00, 1'b0, 3'h0, 1'b0, XA[k][7:0] ^ XA[k][15:8], 1'b0, 1);
			check(16'(re), 16'(k > 4));
		end
		for (int k = 0; k < 5; k++) begin
			dw(IDM_DPH_ADDR, XA[k][15:8]);
			dw(IDM_DPL_ADDR, XA[k][7:0]);
			acc(IDM_EXTERNAL, 1'b0, 8'h00, 1'b0, 3'h0, 1'b0, 8'h00, 1'b0, 1);
			check(16'(rd), 16'(XA[k][7:0] ^ XA[k][15:8]));
		end
		$display("test extended done");
	endtask
	// reset for six cycles, then the scenarios in turn
	initial begin
		fail_count = 0;
		samples_checked = 0;
		rst = 1'b1;
		ce = 1'b1;
		req = 1'b0;
		mode = IDM_DIRECT;
		wr = 1'b0;
		addr = 8'h00;
		use_reg = 1'b0;
		reg_idx = 3'h0;
		ptr_sel = 1'b0;
		wdata = 8'h00;
		bit_wdata = 1'b0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_banks;
		t_indirect;
		t_bits;
		t_ce;
		t_ext;
		summarize;
	end
endmodule // idm_map_tb_top
